// file: hw/dsw_wake_capture.sv
// Contract
// - A pin-change event during deep sleep sets the wake flag at bit 8, otherwise it reads zero; the code also lets a wake-source register write set it.
// - A fault during deep sleep sets the fault flag at bit 7, warning sleep settings may be corrupt.
// - A deep sleep watchdog expiry during deep sleep sets the flag at bit 4, else it stays clear; the code also lets a wake-source register write set it.
// - A calendar alarm during deep sleep sets the flag at bit 3.
// - The master-clear flag at bit 2 sets only when the pin is enabled and asserted during deep sleep; the code also sets it on a wake-source register write of one.
// - Setting the deep sleep enable bit 15 of the control register clears every wake flag; when already asleep the code keeps a same-cycle event's flag.
// - Bits 31-9, 6-5 and 1-0 of the wake-source register read as zero.
//
// Local design decisions: register access over AXI4-Lite and the address map.
`timescale 1ns/10ps
`default_nettype none

module dsw_wake_capture (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // wake event pins (asynchronous)
    input  wire logic        pin_change_in,
    input  wire logic        sleep_fault_in,
    input  wire logic        sleep_wdt_expire_in,
    input  wire logic        calendar_alarm_in,
    input  wire logic        master_clear_pin_n,
    input  wire logic        master_clear_enable,
    // status
    output logic             in_deep_sleep,
    output logic             irq
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    dsw_pkg::dsw_events_t ev_raw;
    dsw_pkg::dsw_events_t ev_s1_q;
    dsw_pkg::dsw_events_t ev_s2_q;
    dsw_pkg::dsw_events_t ev_prev_q;
    dsw_pkg::dsw_events_t ev_rise;
    logic                 master_clear_pin_en_s1_q;
    logic                 master_clear_pin_en_s2_q;

    always_comb begin
        ev_raw.pin_change  = pin_change_in;
        ev_raw.fault       = sleep_fault_in;
        ev_raw.wdt_timeout = sleep_wdt_expire_in;
        ev_raw.alarm       = calendar_alarm_in;
        ev_raw.master_clear_pin_assert = ~master_clear_pin_n;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ev_s1_q      <= '0;
            ev_s2_q      <= '0;
            ev_prev_q    <= '0;
            master_clear_pin_en_s1_q <= 1'b0;
            master_clear_pin_en_s2_q <= 1'b0;
        end else if (clk_en) begin
            ev_s1_q      <= ev_raw;
            ev_s2_q      <= ev_s1_q;
            ev_prev_q    <= ev_s2_q;
            master_clear_pin_en_s1_q <= master_clear_enable;
            master_clear_pin_en_s2_q <= master_clear_pin_en_s1_q;
        end
    end

    // rising edges only, so a stuck-high source cannot refill a flag software just cleared
    assign ev_rise = ev_s2_q & ~ev_prev_q;

    // ------------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------------
    logic        aw_have_q;
    logic [7:0]  aw_addr_q;
    logic        w_have_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        wr_fire;
    logic        ar_fire;

    // readies drop while frozen so a master never sees a transfer that was not taken
    assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid & clk_en;
    assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid & clk_en;
    assign s_axi_arready = ~s_axi_rvalid & clk_en;
    assign wr_fire       = aw_have_q & w_have_q & ~s_axi_bvalid & clk_en;
    assign ar_fire       = s_axi_arvalid & s_axi_arready & clk_en;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_have_q  <= 1'b0;
            w_data_q  <= 32'h00000000;
            w_strb_q  <= 4'h0;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_have_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (wr_fire) begin
                w_have_q <= 1'b0;
            end
        end
    end

    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    function automatic logic addr_known(input logic [7:0] a);
        addr_known = (a == dsw_pkg::WAKE_SRC_OFF) || (a == dsw_pkg::SLEEP_CTL_OFF) ||
                     (a == dsw_pkg::IRQ_STAT_OFF) || (a == dsw_pkg::IRQ_MASK_OFF);
    endfunction

    logic [31:0] wmask;
    logic        wr_wake;
    logic        wr_ctl;
    logic        wr_stat;
    logic        wr_mask;

    assign wmask   = strb_mask(w_strb_q);
    assign wr_wake = wr_fire && (aw_addr_q == dsw_pkg::WAKE_SRC_OFF);
    assign wr_ctl  = wr_fire && (aw_addr_q == dsw_pkg::SLEEP_CTL_OFF);
    assign wr_stat = wr_fire && (aw_addr_q == dsw_pkg::IRQ_STAT_OFF);
    assign wr_mask = wr_fire && (aw_addr_q == dsw_pkg::IRQ_MASK_OFF);

    // ------------------------------------------------------------------
    // deep sleep control
    // ------------------------------------------------------------------
    logic [31:0] ctl_q;
    logic        sleep_enter;

    // any write of a one to the enable bit counts, even when already asleep
    assign sleep_enter = wr_ctl && wmask[dsw_pkg::SLEEP_EN_BIT] && w_data_q[dsw_pkg::SLEEP_EN_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_q <= dsw_pkg::CTL_RESET;
        end else if (clk_en) begin
            if (wr_ctl) begin
                ctl_q[dsw_pkg::SLEEP_EN_BIT] <= (ctl_q[dsw_pkg::SLEEP_EN_BIT] & ~wmask[dsw_pkg::SLEEP_EN_BIT])
                                              | (w_data_q[dsw_pkg::SLEEP_EN_BIT] & wmask[dsw_pkg::SLEEP_EN_BIT]);
            end
        end
    end

    assign in_deep_sleep = ctl_q[dsw_pkg::SLEEP_EN_BIT];

    // ------------------------------------------------------------------
    // wake-source flags
    // ------------------------------------------------------------------
    logic [31:0] wake_q;
    logic [31:0] wake_set;
    logic [31:0] wake_d;

    always_comb begin
        wake_set = 32'h00000000;
        if (in_deep_sleep) begin
            wake_set[dsw_pkg::PIN_CHANGE_BIT] = ev_rise.pin_change;
            wake_set[dsw_pkg::FAULT_BIT]      = ev_rise.fault;
            wake_set[dsw_pkg::WDT_BIT]        = ev_rise.wdt_timeout;
            wake_set[dsw_pkg::ALARM_BIT]      = ev_rise.alarm;
            wake_set[dsw_pkg::MASTER_CLEAR_PIN_BIT]       = ev_rise.master_clear_pin_assert & master_clear_pin_en_s2_q;
        end
        wake_d = wake_q;
        if (sleep_enter) begin
            wake_d = 32'h00000000;
        end else if (wr_wake) begin
            wake_d = (wake_q & ~wmask) | (w_data_q & wmask);
        end
        // a simultaneous event beats the clear so it is never lost
        wake_d = (wake_d | wake_set) & dsw_pkg::WAKE_IMPL_MASK;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_q <= dsw_pkg::WAKE_RESET;
        end else if (clk_en) begin
            wake_q <= wake_d;
        end
    end

    // ------------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------------
    logic [31:0] istat_q;
    logic [31:0] imask_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            istat_q <= 32'h00000000;
        end else if (clk_en) begin
            // write one to clear; a new event in the same cycle wins
            istat_q <= ((istat_q & ~(wr_stat ? (w_data_q & wmask) : 32'h00000000)) | wake_set)
                       & dsw_pkg::WAKE_IMPL_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            imask_q <= dsw_pkg::MASK_RESET;
        end else if (clk_en) begin
            if (wr_mask) begin
                imask_q <= ((imask_q & ~wmask) | (w_data_q & wmask)) & dsw_pkg::WAKE_IMPL_MASK;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'b0;
        end else if (clk_en) begin
            irq <= |(istat_q & imask_q);
        end
    end

    // ------------------------------------------------------------------
    // write response
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= dsw_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= addr_known(aw_addr_q) ? dsw_pkg::RESP_OKAY : dsw_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    logic [31:0] rd_mux;

    always_comb begin
        case (s_axi_araddr)
            dsw_pkg::WAKE_SRC_OFF:  rd_mux = wake_q & dsw_pkg::WAKE_IMPL_MASK;
            dsw_pkg::SLEEP_CTL_OFF: rd_mux = ctl_q;
            dsw_pkg::IRQ_STAT_OFF:  rd_mux = istat_q;
            dsw_pkg::IRQ_MASK_OFF:  rd_mux = imask_q;
            default:                rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= dsw_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (ar_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= addr_known(s_axi_araddr) ? dsw_pkg::RESP_OKAY : dsw_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // dsw_wake_capture

`default_nettype wire

// file: hw/dsw_pkg.sv
package dsw_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] WAKE_SRC_OFF  = 8'h00;
    localparam logic [7:0] SLEEP_CTL_OFF = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFF  = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFF  = 8'h0C;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int PIN_CHANGE_BIT = 8;
    localparam int FAULT_BIT      = 7;
    localparam int WDT_BIT        = 4;
    localparam int ALARM_BIT      = 3;
    localparam int MASTER_CLEAR_PIN_BIT       = 2;
    localparam int SLEEP_EN_BIT   = 15;

    localparam logic [31:0] WAKE_IMPL_MASK = 32'h0000019C;
    localparam logic [31:0] WAKE_RESET     = 32'h00000000;
    localparam logic [31:0] CTL_RESET      = 32'h00000000;
    localparam logic [31:0] MASK_RESET     = 32'h00000000;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic pin_change;
        logic fault;
        logic wdt_timeout;
        logic alarm;
        logic master_clear_pin_assert;
    } dsw_events_t;

endpackage

// file: bench/dsw_wake_capture_assertions.sv
`timescale 1ns/10ps
`default_nettype none

module dsw_wake_capture_checker (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        clk_en,
    // write side
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // read side
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // status
    input wire logic        in_deep_sleep,
    input wire logic        irq
);
    // ------------------------------------------------------------
    // address and data of the transfer in flight
    // ------------------------------------------------------------
    logic [7:0] aw_q;
    logic [7:0] ar_q;
    logic [1:0] w_q;
    always_ff @(posedge aclk) begin
        if (s_axi_awvalid && s_axi_awready && clk_en) aw_q <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready && clk_en) w_q <= {s_axi_wstrb[1], s_axi_wdata[15]};
        if (s_axi_arvalid && s_axi_arready && clk_en) ar_q <= s_axi_araddr;
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready && clk_en;
    endsequence

    a_wr_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    a_rd_answer: assert property (s_rd_take |=> s_axi_rvalid) else $error("read answer late");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_b_done: assert property (s_axi_bvalid && s_axi_bready && clk_en |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_bus_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready && 1'b1)
        else $error("write taken while response pending");
    a_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    a_resp_map: assert property ($rose(s_axi_bvalid) |-> s_axi_bresp == ((aw_q[7:4] == 4'h0
        && aw_q[1:0] == 2'h0) ? dsw_pkg::RESP_OKAY : dsw_pkg::RESP_SLVERR)) else $error("wrong write response");
    a_rd_unimpl: assert property (s_axi_rvalid && ar_q == dsw_pkg::WAKE_SRC_OFF |->
        (s_axi_rdata & ~dsw_pkg::WAKE_IMPL_MASK) == 32'h00000000) else $error("unused wake bits not zero");
    a_sleep_bit: assert property ($rose(s_axi_bvalid) && aw_q == dsw_pkg::SLEEP_CTL_OFF && w_q[1]
        |-> in_deep_sleep == w_q[0]) else $error("sleep state differs from control write");
    // reset must quiet the outputs even though assertions are otherwise off in reset
    a_reset_quiet: assert property (disable iff (1'b0) !aresetn && clk_en |=> !s_axi_bvalid && !s_axi_rvalid
        && !irq && !in_deep_sleep) else $error("outputs active after reset");
endmodule // dsw_wake_capture_checker

bind dsw_wake_capture dsw_wake_capture_checker dsw_wake_capture_checker_inst (
    .aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .in_deep_sleep, .irq
);

`default_nettype wire

// file: bench/test_dsw_wake_capture.sv
`timescale 1ns/10ps
`default_nettype none

module test_dsw_wake_capture;
    logic                 aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, master_clear_enable = 1'b0;
    logic [7:0]           s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0]          s_axi_wdata = 32'h00000000, s_axi_rdata, seed = 32'hF5D1, acc;
    logic [3:0]           s_axi_wstrb = 4'hF;
    logic [1:0]           s_axi_bresp, s_axi_rresp;
    logic                 s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic                 s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic                 s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic                 in_deep_sleep, irq;
    dsw_pkg::dsw_events_t ev = '0;
    logic [33:0]          exp_q[$];
    int                   n_mismatch = 0, cmp_count = 0;
    localparam int        BITS [5] = '{dsw_pkg::MASTER_CLEAR_PIN_BIT, dsw_pkg::ALARM_BIT, dsw_pkg::WDT_BIT,
                                       dsw_pkg::FAULT_BIT, dsw_pkg::PIN_CHANGE_BIT};

    dsw_wake_capture dsw_wake_capture_inst (
        .aclk, .aresetn, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .pin_change_in(ev.pin_change), .sleep_fault_in(ev.fault),
        .sleep_wdt_expire_in(ev.wdt_timeout), .calendar_alarm_in(ev.alarm),
        .master_clear_pin_n(!ev.master_clear_pin_assert), .master_clear_enable, .in_deep_sleep, .irq
    );

    always #20 aclk = ~aclk;

    // ------------------------------------------------------------
    // checking and bus tasks
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] want);
        cmp_count++;
        if (seen !== want) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, want, seen);
        end
    endtask

    always @(posedge aclk) begin
        if ((s_axi_rvalid & s_axi_rready) === 1'b1) chk("read", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
        if ((s_axi_bvalid & s_axi_bready) === 1'b1) chk("write", {s_axi_bresp, 32'h00000000}, exp_q.pop_front());
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = dsw_pkg::RESP_OKAY);
        exp_q.push_back({r, 32'h00000000});
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = dsw_pkg::RESP_OKAY);
        exp_q.push_back({r, d});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask

    // long enough to cross the two-stage synchronizer and the edge detector
    task automatic pulse(input int i);
        ev[i] <= 1'b1;
        repeat (6) @(posedge aclk);
        ev[i] <= 1'b0;
        repeat (6) @(posedge aclk);
    endtask

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(dsw_pkg::WAKE_SRC_OFF, dsw_pkg::WAKE_RESET);
        rd(dsw_pkg::SLEEP_CTL_OFF, dsw_pkg::CTL_RESET);
        rd(dsw_pkg::IRQ_MASK_OFF, dsw_pkg::MASK_RESET);
        rd(8'h10, 32'h00000000, dsw_pkg::RESP_SLVERR);
        wr(8'h14, 32'hFFFFFFFF, dsw_pkg::RESP_SLVERR);
        for (int i = 0; i < 5; i++) pulse(i);
        rd(dsw_pkg::WAKE_SRC_OFF, 32'h00000000);
        wr(dsw_pkg::SLEEP_CTL_OFF, 32'h00008000);
        rd(dsw_pkg::SLEEP_CTL_OFF, 32'h00008000);
        pulse(0);
        rd(dsw_pkg::WAKE_SRC_OFF, 32'h00000000);
        master_clear_enable <= 1'b1;
        acc = 32'h00000000;
        for (int i = 0; i < 5; i++) begin
            pulse(i);
            acc[BITS[i]] = 1'b1;
            rd(dsw_pkg::WAKE_SRC_OFF, acc);
        end
        chk("irq masked", {33'h0, irq}, 34'h0);
        wr(dsw_pkg::IRQ_MASK_OFF, dsw_pkg::WAKE_IMPL_MASK);
        chk("irq raised", {33'h0, irq}, 34'h1);
        rd(dsw_pkg::IRQ_STAT_OFF, acc);
        wr(dsw_pkg::IRQ_STAT_OFF, acc);
        rd(dsw_pkg::IRQ_STAT_OFF, 32'h00000000);
        chk("irq cleared", {33'h0, irq}, 34'h0);
        // re-arming while already asleep must still wipe the flags
        wr(dsw_pkg::SLEEP_CTL_OFF, 32'h00008000);
        rd(dsw_pkg::WAKE_SRC_OFF, 32'h00000000);
        // a frozen block must not see an event that comes and goes while frozen
        clk_en <= 1'b0;
        pulse(1);
        clk_en <= 1'b1;
        rd(dsw_pkg::WAKE_SRC_OFF, 32'h00000000);
        repeat (8) begin
            seed = xs(seed);
            wr(dsw_pkg::WAKE_SRC_OFF, seed);
            rd(dsw_pkg::WAKE_SRC_OFF, seed & dsw_pkg::WAKE_IMPL_MASK);
        end
        final_report();
    end

    initial begin
        #(40 * 5000);
        n_mismatch++;
        final_report();
    end
endmodule // test_dsw_wake_capture

`default_nettype wire
